// ==== logic/flic_pkg.sv ====
// Package of constants and carriers for the four-level interrupt controller
package flic_pkg;
    localparam int NUM_SRC   = 11;
    localparam int LVL_W     = 2;
    localparam int VEC_W     = 16;
    localparam int PHASE_W   = 2;
    localparam int MC_CLOCKS = 4;
    localparam logic [PHASE_W-1:0] PHASE_C3 = 2'h2;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
    localparam int CALL_MC   = 4;
    localparam logic [2:0] CALL_MC_CNT = 3'h4;
    // Response figures in machine cycles, with the maximum also given in clocks
    localparam int MIN_RESPONSE_MC = 5;
    localparam int MAX_RESPONSE_MC = 12;
    localparam int MAX_RESPONSE_CLK = MAX_RESPONSE_MC * MC_CLOCKS;
    // Source index, also the bit position in enable and priority words
    localparam int SRC_EXT0  = 0;
    localparam int SRC_TMRA  = 1;
    localparam int SRC_EXT1  = 2;
    localparam int SRC_TMRB  = 3;
    localparam int SRC_SER   = 4;
    localparam int SRC_TMRC  = 5;
    localparam int SRC_TWW   = 6;
    localparam int SRC_KEY   = 7;
    localparam int SRC_WDOG  = 8;
    localparam int SRC_BROWN = 9;
    localparam int SRC_CAPT  = 10;
    localparam logic [VEC_W-1:0] VEC_EXT0  = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_TMRA  = 16'h000B;
    localparam logic [VEC_W-1:0] VEC_EXT1  = 16'h0013;
    localparam logic [VEC_W-1:0] VEC_TMRB  = 16'h001B;
    localparam logic [VEC_W-1:0] VEC_SER   = 16'h0023;
    localparam logic [VEC_W-1:0] VEC_BROWN = 16'h002B;
    localparam logic [VEC_W-1:0] VEC_TWW   = 16'h0033;
    localparam logic [VEC_W-1:0] VEC_KEY   = 16'h003B;
    localparam logic [VEC_W-1:0] VEC_TMRC  = 16'h0043;
    localparam logic [VEC_W-1:0] VEC_WDOG  = 16'h0053;
    localparam logic [VEC_W-1:0] VEC_CAPT  = 16'h006B;
    typedef logic [NUM_SRC-1:0] flic_src_t;
    typedef struct packed {
        logic instr_last_mc;
        logic instr_writes_irq_reg;
        logic instr_is_return_from_interrupt;
    } flic_core_s;
    typedef struct packed {
        logic             call_valid;
        logic [VEC_W-1:0] vector_addr;
        logic [3:0]       src_index;
        logic [LVL_W-1:0] level;
    } flic_call_s;
endpackage : flic_pkg

// ==== logic/flic_ext_cond.sv ====
// External interrupt pin conditioner: level or falling-edge flag
`timescale 1ns/10ps
module flic_ext_cond (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic pin_i,
    input  wire logic sample_i,
    input  wire logic trigger_type_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic flag;
    } flic_ec_s;
    flic_ec_s st_q;
    flic_ec_s st_d;

    always_comb begin
        st_d       = st_q;
        st_d.sync1 = pin_i;
        st_d.sync2 = st_q.sync1;
        if (sample_i) begin
            st_d.prev = st_q.sync2;
            if (!trigger_type_i) begin
                // Flag tracks a low pin level
                st_d.flag = ~st_q.sync2;
            end else if (st_q.prev && !st_q.sync2) begin
                st_d.flag = 1'b1;
            end else if (clear_i) begin
                st_d.flag = 1'b0;
            end
        end else if (clear_i && trigger_type_i) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            st_q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, flag: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;
endmodule : flic_ext_cond

// ==== logic/flic_ctrl.sv ====
// Four-level interrupt controller: arbitration, vector call, in-service
`timescale 1ns/10ps
// How it works
// - Two priority bits per source select level zero to three.
// - Only a strictly higher level preempts; level three never preempted.
// - Higher level wins; equal level uses fixed ranking ext0 first.
// - Flags sampled, polled and resolved every machine cycle.
// - Call only if no equal/higher in service, last cycle, no blocking op.
// - Untaken requests are not remembered between polls.
// - Call pushes return address, not status word, loads vector.
// - Each source has its fixed vector address.
// - Interrupt return ends current level; plain return does not.
// - Timer a/b and edge-mode external flags cleared on vectoring.
// - Per-source enables plus a global enable gating all sources.
// - Vector call lasts four machine cycles.
// - Single-interrupt response at most twelve machine cycles.
// - External pins sampled in third clock phase each machine cycle.
// - Trigger type zero means low level; one means falling edge.
// - Level-mode flag follows the pin and re-requests if held.
// - Named enabled sources wake power-down; external wakes idle.
module flic_ctrl #(
    parameter int NUM_SRC = flic_pkg::NUM_SRC
) (
    input  wire logic                         clk_sys_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         ext0_pin_i,
    input  wire logic                         ext1_pin_i,
    input  wire logic                         ext0_trigger_type_i,
    input  wire logic                         ext1_trigger_type_i,
    input  wire logic                         timer_a_overflow_flag_i,
    input  wire logic                         timer_b_overflow_flag_i,
    input  wire logic                         timer_c_overflow_flag_i,
    input  wire logic                         timer_c_external_flag_i,
    input  wire logic                         serial_rx_flag_i,
    input  wire logic                         serial_tx_flag_i,
    input  wire logic                         twowire_irq_flag_i,
    input  wire logic                         twowire_timeout_flag_i,
    input  wire logic                         keypad_flag_i,
    input  wire logic                         watchdog_irq_flag_i,
    input  wire logic                         watchdog_on_rc_i,
    input  wire logic                         brownout_flag_i,
    input  wire logic                         capture_flag_i,
    input  wire logic                         global_irq_enable_i,
    input  wire logic [NUM_SRC-1:0]           src_enable_i,
    input  wire logic [NUM_SRC-1:0]           priority_high_bit_i,
    input  wire logic [NUM_SRC-1:0]           priority_low_bit_i,
    input  wire flic_pkg::flic_core_s         core_i,
    output flic_pkg::flic_call_s              call_o,
    output logic                              call_busy_o,
    output logic                              timer_a_flag_clear_o,
    output logic                              timer_b_flag_clear_o,
    output logic                              ext0_request_flag_o,
    output logic                              ext1_request_flag_o,
    output logic [3:0]                        in_service_o,
    output logic                              wake_power_down_o,
    output logic                              wake_idle_o
);
    typedef enum logic [1:0] {
        ST_POLL,
        ST_CALL
    } flic_state_e;

    typedef struct packed {
        flic_state_e            state;
        logic [1:0]             phase;
        logic [2:0]             call_cnt;
        logic [3:0]             in_service;
        flic_pkg::flic_call_s   call;
        logic                   busy;
        logic                   clr_a;
        logic                   clr_b;
        logic                   clr_e0;
        logic                   clr_e1;
        logic                   wake_pd;
        logic                   wake_idle;
    } flic_ctrl_s;

    flic_ctrl_s st_q;
    flic_ctrl_s st_d;

    logic                 ext0_flag;
    logic                 ext1_flag;
    logic                 sample_c3;
    logic [NUM_SRC-1:0]   req;
    logic [NUM_SRC-1:0]   pending;
    logic [1:0]           lvl [NUM_SRC];
    logic                 win_found;
    logic [3:0]           win_idx;
    logic [1:0]           win_lvl;

    // Ranking order, first entry wins ties
    localparam int RANK [11] = '{
        flic_pkg::SRC_EXT0, flic_pkg::SRC_BROWN, flic_pkg::SRC_WDOG,
        flic_pkg::SRC_TMRA, flic_pkg::SRC_TWW,   flic_pkg::SRC_EXT1,
        flic_pkg::SRC_KEY,  flic_pkg::SRC_TMRB,  flic_pkg::SRC_SER,
        flic_pkg::SRC_TMRC, flic_pkg::SRC_CAPT
    };

    function automatic logic [flic_pkg::VEC_W-1:0] vec_of(
        input logic [3:0] idx
    );
        case (idx)
            4'(flic_pkg::SRC_EXT0):  vec_of = flic_pkg::VEC_EXT0;
            4'(flic_pkg::SRC_TMRA):  vec_of = flic_pkg::VEC_TMRA;
            4'(flic_pkg::SRC_EXT1):  vec_of = flic_pkg::VEC_EXT1;
            4'(flic_pkg::SRC_TMRB):  vec_of = flic_pkg::VEC_TMRB;
            4'(flic_pkg::SRC_SER):   vec_of = flic_pkg::VEC_SER;
            4'(flic_pkg::SRC_TMRC):  vec_of = flic_pkg::VEC_TMRC;
            4'(flic_pkg::SRC_TWW):   vec_of = flic_pkg::VEC_TWW;
            4'(flic_pkg::SRC_KEY):   vec_of = flic_pkg::VEC_KEY;
            4'(flic_pkg::SRC_WDOG):  vec_of = flic_pkg::VEC_WDOG;
            4'(flic_pkg::SRC_BROWN): vec_of = flic_pkg::VEC_BROWN;
            4'(flic_pkg::SRC_CAPT):  vec_of = flic_pkg::VEC_CAPT;
            default:                 vec_of = flic_pkg::VEC_EXT0;
        endcase
    endfunction : vec_of

    // Highest level currently in service, or four when idle
    function automatic logic [2:0] top_active(input logic [3:0] act);
        top_active = 3'h4;
        for (int l = 0; l < 4; l++) begin
            if (act[l]) begin
                top_active = 3'(l);
            end
        end
    endfunction : top_active

    assign sample_c3 = (st_q.phase == flic_pkg::PHASE_C3);

    flic_ext_cond u_ext0 (
        .clk_sys_i      (clk_sys_i),
        .reset_n_i      (reset_n_i),
        .pin_i          (ext0_pin_i),
        .sample_i       (sample_c3),
        .trigger_type_i (ext0_trigger_type_i),
        .clear_i        (st_q.clr_e0),
        .flag_o         (ext0_flag)
    );

    flic_ext_cond u_ext1 (
        .clk_sys_i      (clk_sys_i),
        .reset_n_i      (reset_n_i),
        .pin_i          (ext1_pin_i),
        .sample_i       (sample_c3),
        .trigger_type_i (ext1_trigger_type_i),
        .clear_i        (st_q.clr_e1),
        .flag_o         (ext1_flag)
    );

    always_comb begin
        req = '0;
        req[flic_pkg::SRC_EXT0]  = ext0_flag;
        req[flic_pkg::SRC_TMRA]  = timer_a_overflow_flag_i;
        req[flic_pkg::SRC_EXT1]  = ext1_flag;
        req[flic_pkg::SRC_TMRB]  = timer_b_overflow_flag_i;
        req[flic_pkg::SRC_SER]   = serial_rx_flag_i | serial_tx_flag_i;
        req[flic_pkg::SRC_TMRC]  = timer_c_overflow_flag_i
                                 | timer_c_external_flag_i;
        req[flic_pkg::SRC_TWW]   = twowire_irq_flag_i | twowire_timeout_flag_i;
        req[flic_pkg::SRC_KEY]   = keypad_flag_i;
        req[flic_pkg::SRC_WDOG]  = watchdog_irq_flag_i;
        req[flic_pkg::SRC_BROWN] = brownout_flag_i;
        req[flic_pkg::SRC_CAPT]  = capture_flag_i;
    end

    // Gate with own enable and global enable
    assign pending = req & src_enable_i
                   & {NUM_SRC{global_irq_enable_i}};

    for (genvar g = 0; g < NUM_SRC; g++) begin : g_lvl
        assign lvl[g] = {priority_high_bit_i[g], priority_low_bit_i[g]};
    end

    // Live resolution, nothing is latched between polls
    always_comb begin
        win_found = 1'b0;
        win_idx   = '0;
        win_lvl   = '0;
        for (int r = 0; r < NUM_SRC; r++) begin
            if (pending[RANK[r]] &&
                (!win_found || lvl[RANK[r]] > win_lvl)) begin
                win_found = 1'b1;
                win_idx   = 4'(RANK[r]);
                win_lvl   = lvl[RANK[r]];
            end
        end
    end

    always_comb begin
        logic [2:0] top;
        logic       may_preempt;
        top         = top_active(st_q.in_service);
        may_preempt = (top == 3'h4) || ({1'b0, win_lvl} > top);
        st_d        = st_q;
        st_d.phase  = st_q.phase + 2'h1;
        st_d.clr_a  = 1'b0;
        st_d.clr_b  = 1'b0;
        st_d.clr_e0 = 1'b0;
        st_d.clr_e1 = 1'b0;
        st_d.call.call_valid = 1'b0;
        case (st_q.state)
            ST_POLL: begin
                // Poll on the last clock of each machine cycle
                if (st_q.phase == flic_pkg::PHASE_LAST) begin
                    if (core_i.instr_is_return_from_interrupt &&
                        top != 3'h4) begin
                        st_d.in_service[top[1:0]] = 1'b0;
                    end
                    if (win_found && may_preempt && core_i.instr_last_mc &&
                        !core_i.instr_writes_irq_reg &&
                        !core_i.instr_is_return_from_interrupt) begin
                        st_d.state = ST_CALL;
                        st_d.call_cnt = 3'h1;
                        st_d.busy  = 1'b1;
                        st_d.in_service[win_lvl] = 1'b1;
                        st_d.call.call_valid  = 1'b1;
                        st_d.call.vector_addr = vec_of(win_idx);
                        st_d.call.src_index   = win_idx;
                        st_d.call.level       = win_lvl;
                        st_d.clr_a  = (win_idx == 4'(flic_pkg::SRC_TMRA));
                        st_d.clr_b  = (win_idx == 4'(flic_pkg::SRC_TMRB));
                        st_d.clr_e0 = (win_idx == 4'(flic_pkg::SRC_EXT0));
                        st_d.clr_e1 = (win_idx == 4'(flic_pkg::SRC_EXT1));
                    end
                end
            end
            ST_CALL: begin
                if (st_q.phase == flic_pkg::PHASE_LAST) begin
                    if (st_q.call_cnt == flic_pkg::CALL_MC_CNT) begin
                        st_d.state = ST_POLL;
                        st_d.busy  = 1'b0;
                    end else begin
                        st_d.call_cnt = st_q.call_cnt + 3'h1;
                    end
                end
            end
            default: begin
                st_d.state = ST_POLL;
                st_d.busy  = 1'b0;
            end
        endcase
        st_d.wake_pd = (pending[flic_pkg::SRC_EXT0]
                     | pending[flic_pkg::SRC_EXT1]
                     | pending[flic_pkg::SRC_BROWN]
                     | pending[flic_pkg::SRC_KEY]
                     | (pending[flic_pkg::SRC_WDOG] & watchdog_on_rc_i));
        st_d.wake_idle = pending[flic_pkg::SRC_EXT0]
                       | pending[flic_pkg::SRC_EXT1];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            st_q <= '{state: ST_POLL, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign call_o               = st_q.call;
    assign call_busy_o          = st_q.busy;
    assign timer_a_flag_clear_o = st_q.clr_a;
    assign timer_b_flag_clear_o = st_q.clr_b;
    assign ext0_request_flag_o  = ext0_flag;
    assign ext1_request_flag_o  = ext1_flag;
    assign in_service_o         = st_q.in_service;
    assign wake_power_down_o    = st_q.wake_pd;
    assign wake_idle_o          = st_q.wake_idle;
endmodule : flic_ctrl

// ==== test/flic_ctrl_monitor.sv ====
// Concurrent checks on the interrupt controller ports
`timescale 1ns/10ps
module flic_ctrl_monitor #(
    parameter int NUM_SRC = flic_pkg::NUM_SRC
) (
    input wire logic                 clk_sys_i,
    input wire logic                 reset_n_i,
    input wire logic                 global_irq_enable_i,
    input wire logic [NUM_SRC-1:0]   src_enable_i,
    input wire logic [NUM_SRC-1:0]   priority_high_bit_i,
    input wire logic [NUM_SRC-1:0]   priority_low_bit_i,
    input wire flic_pkg::flic_core_s core_i,
    input wire flic_pkg::flic_call_s call_o,
    input wire logic                 call_busy_o,
    input wire logic                 timer_a_flag_clear_o,
    input wire logic                 timer_b_flag_clear_o,
    input wire logic [3:0]           in_service_o
);
    localparam logic [15:0] VEC_TBL [11] = '{flic_pkg::VEC_EXT0,
        flic_pkg::VEC_TMRA, flic_pkg::VEC_EXT1, flic_pkg::VEC_TMRB,
        flic_pkg::VEC_SER, flic_pkg::VEC_TMRC, flic_pkg::VEC_TWW,
        flic_pkg::VEC_KEY, flic_pkg::VEC_WDOG, flic_pkg::VEC_BROWN,
        flic_pkg::VEC_CAPT};
    logic [4:0] busy_len_q;
    function automatic logic bit_at(logic [NUM_SRC-1:0] v, logic [3:0] i);
        return v[i];
    endfunction : bit_at
    // Length of the current busy stretch
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !call_busy_o) begin
            busy_len_q <= 5'h0;
        end else begin
            busy_len_q <= busy_len_q + 5'h1;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_call_one_pulse: assert property (
        call_o.call_valid |=> !call_o.call_valid && call_busy_o)
        else $error("call valid is not a single pulse");
    a_busy_four_mc: assert property (
        $fell(call_busy_o) |-> busy_len_q == 5'h10)
        else $error("call busy span is not four machine cycles");
    a_call_gating: assert property (
        call_o.call_valid |-> $past(core_i.instr_last_mc) &&
        !$past(core_i.instr_writes_irq_reg) &&
        !$past(core_i.instr_is_return_from_interrupt) && !$past(call_busy_o))
        else $error("call issued in a blocked cycle");
    a_enable_gate: assert property (
        call_o.call_valid |-> $past(global_irq_enable_i) &&
        bit_at($past(src_enable_i), call_o.src_index))
        else $error("call for a disabled source");
    a_level_bits: assert property (
        call_o.call_valid |-> call_o.level ==
        {bit_at($past(priority_high_bit_i), call_o.src_index),
         bit_at($past(priority_low_bit_i), call_o.src_index)})
        else $error("call level does not match priority bits");
    a_strictly_higher: assert property (
        call_o.call_valid |-> ($past(in_service_o) >> call_o.level) == 4'h0)
        else $error("call at or below an in-service level");
    a_service_marked: assert property (
        call_o.call_valid |-> in_service_o[call_o.level])
        else $error("called level not marked in service");
    a_vector_table: assert property (
        call_o.call_valid |-> call_o.vector_addr == VEC_TBL[call_o.src_index])
        else $error("wrong vector address");
    a_timer_clears: assert property (
        {timer_a_flag_clear_o, timer_b_flag_clear_o} ==
        {call_o.call_valid && call_o.src_index == 4'h1,
         call_o.call_valid && call_o.src_index == 4'h3})
        else $error("timer flag clear mismatch");
    c_level3_call: cover property (call_o.call_valid && call_o.level == 2'h3);
    c_preempt: cover property (call_o.call_valid && $past(in_service_o) != 4'h0);
    c_timer_clear: cover property (timer_a_flag_clear_o);
endmodule : flic_ctrl_monitor

bind flic_ctrl flic_ctrl_monitor #(.NUM_SRC(NUM_SRC)) i_mon (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .global_irq_enable_i(global_irq_enable_i), .src_enable_i(src_enable_i),
    .priority_high_bit_i(priority_high_bit_i),
    .priority_low_bit_i(priority_low_bit_i), .core_i(core_i),
    .call_o(call_o), .call_busy_o(call_busy_o),
    .timer_a_flag_clear_o(timer_a_flag_clear_o),
    .timer_b_flag_clear_o(timer_b_flag_clear_o), .in_service_o(in_service_o));

// ==== test/flic_core_model.sv ====
// Core sequencer model giving instruction status per machine cycle
`timescale 1ns/10ps
module flic_core_model (
    input  wire logic            clk_sys_i,
    input  wire logic            reset_n_i,
    input  wire logic [1:0]      mode_i,
    input  wire logic            ret_req_i,
    output flic_pkg::flic_core_s core_o
);
    logic [1:0] phase_q;
    logic       odd_q;
    logic       ret_pend_q;
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            phase_q <= 2'h0;
            odd_q <= 1'b0;
            ret_pend_q <= 1'b0;
            core_o <= '0;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (ret_req_i) begin
                ret_pend_q <= 1'b1;
            end
            // Mode 1 writes irq registers, mode 2 runs two-cycle ops
            if (phase_q == 2'h3) begin
                odd_q <= !odd_q;
                ret_pend_q <= 1'b0;
                core_o.instr_last_mc <= (mode_i != 2'h2) || odd_q;
                core_o.instr_writes_irq_reg <= (mode_i == 2'h1);
                core_o.instr_is_return_from_interrupt <=
                    ret_pend_q || ret_req_i;
            end
        end
    end
endmodule : flic_core_model

// ==== test/testbench.sv ====
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/10ps
module testbench;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [10:0] flg = '0;
    logic        alt = 1'b0;
    logic        pin0 = 1'b1;
    logic        pin1 = 1'b1;
    logic [1:0]  trig = 2'h0;
    logic        wd_rc = 1'b0;
    logic        glob = 1'b1;
    logic [10:0] en = '0;
    logic [10:0] hi = '0;
    logic [10:0] lo = '0;
    logic [1:0]  mode = 2'h0;
    logic        ret = 1'b0;
    logic        busy, clr_a, clr_b, rq0, rq1, wk_pd, wk_id;
    logic [3:0]  insvc;
    flic_pkg::flic_core_s core;
    flic_pkg::flic_call_s call;
    int          num_errors = 0;
    int          check_count = 0;
    // Request sets, priority bits, expected winner and level
    localparam logic [10:0] RQ [10] = '{11'h206, 11'h112, 11'h0CC,
        11'h4BC, 11'h438, 11'h430, 11'h201, 11'h403, 11'h081, 11'h003};
    localparam logic [10:0] HI [10] = '{11'h000, 11'h000, 11'h000,
        11'h000, 11'h000, 11'h000, 11'h000, 11'h400, 11'h081, 11'h000};
    localparam logic [10:0] LO [10] = '{11'h7FF, 11'h000, 11'h000,
        11'h000, 11'h000, 11'h000, 11'h000, 11'h003, 11'h080, 11'h002};
    localparam int WIN [10] = '{9, 8, 6, 2, 3, 4, 0, 10, 7, 1};
    localparam int LV [10] = '{1, 0, 0, 0, 0, 0, 0, 2, 3, 1};

    flic_ctrl i_dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .ext0_pin_i(pin0 & !flg[0]), .ext1_pin_i(pin1 & !flg[2]),
        .ext0_trigger_type_i(trig[0]), .ext1_trigger_type_i(trig[1]),
        .timer_a_overflow_flag_i(flg[1]), .timer_b_overflow_flag_i(flg[3]),
        .timer_c_overflow_flag_i(flg[5] & !alt),
        .timer_c_external_flag_i(flg[5] & alt),
        .serial_rx_flag_i(flg[4] & !alt), .serial_tx_flag_i(flg[4] & alt),
        .twowire_irq_flag_i(flg[6] & !alt),
        .twowire_timeout_flag_i(flg[6] & alt),
        .keypad_flag_i(flg[7]), .watchdog_irq_flag_i(flg[8]),
        .watchdog_on_rc_i(wd_rc), .brownout_flag_i(flg[9]),
        .capture_flag_i(flg[10]), .global_irq_enable_i(glob),
        .src_enable_i(en), .priority_high_bit_i(hi),
        .priority_low_bit_i(lo), .core_i(core), .call_o(call),
        .call_busy_o(busy), .timer_a_flag_clear_o(clr_a),
        .timer_b_flag_clear_o(clr_b), .ext0_request_flag_o(rq0),
        .ext1_request_flag_o(rq1), .in_service_o(insvc),
        .wake_power_down_o(wk_pd), .wake_idle_o(wk_id));
    flic_core_model i_core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .mode_i(mode), .ret_req_i(ret), .core_o(core));

    always #10 clk_sys_i = !clk_sys_i;

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic take(input int src, input int lvl, input int lim);
        int k;
        k = 0;
        while (call.call_valid !== 1'b1 && k < lim) begin
            tick(1);
            k++;
        end
        chk(k < lim, "no call in time");
        chk(call.src_index === 4'(src) && call.level === 2'(lvl), "winner");
        tick(1);
    endtask : take
    task automatic none(input int lim);
        repeat (lim) begin
            tick(1);
            chk(call.call_valid === 1'b0, "unexpected call");
        end
    endtask : none
    task automatic rti();
        ret = 1'b1;
        tick(1);
        ret = 1'b0;
    endtask : rti
    task automatic retire(input logic [3:0] exp);
        flg = '0;
        tick(16);
        rti();
        tick(12);
        chk(insvc === exp, "in service after return");
    endtask : retire
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    initial begin
        #200_000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        reset_n_i = 1'b1;
        chk(insvc === 4'h0 && busy === 1'b0 && call.call_valid === 1'b0, "rst");
        // Each source alone, both halves of paired sources
        for (int p = 0; p < 2; p++) begin
            alt = p[0];
            wd_rc = p[0];
            for (int i = 0; i < 11; i++) begin
                en = 11'h1 << i;
                flg[i] = 1'b1;
                take(i, 0, (i == 0 || i == 2) ? 12 : 6);
                chk(wk_pd === (i inside {0, 2, 7, 9} || (i == 8 && p == 1)),
                    "power-down wake");
                chk(wk_id === (i inside {0, 2}), "idle wake");
                retire(4'h0);
            end
        end
        for (int t = 0; t < 10; t++) begin
            // Let pin-borne requests reach their flags first
            en = '0;
            flg = RQ[t];
            hi = HI[t];
            lo = LO[t];
            tick(8);
            en = '1;
            take(WIN[t], LV[t], 12);
            retire(4'h0);
        end
        // Equal level waits, higher preempts, returns unwind in order
        hi = 11'h400;
        lo = 11'h00A;
        flg[3] = 1'b1;
        take(3, 1, 12);
        flg = '0;
        tick(16);
        flg[1] = 1'b1;
        none(40);
        flg[10] = 1'b1;
        take(10, 2, 12);
        chk(insvc === 4'h6, "nested levels");
        flg[10] = 1'b0;
        tick(16);
        rti();
        none(20);
        chk(insvc === 4'h2, "top level retired");
        rti();
        take(1, 1, 24);
        retire(4'h0);
        // Blocked requests are dropped once the flag goes away
        hi = '0;
        lo = '0;
        for (int b = 0; b < 3; b++) begin
            glob = (b != 0);
            en = (b == 1) ? 11'h7FD : '1;
            mode = (b == 2) ? 2'h1 : 2'h0;
            // Core shows a new mode one machine cycle late
            tick(8);
            flg[1] = 1'b1;
            none(24);
            flg[1] = 1'b0;
            glob = 1'b1;
            en = '1;
            mode = 2'h0;
            none(24);
        end
        mode = 2'h2;
        tick(8);
        flg[1] = 1'b1;
        take(1, 0, 12);
        mode = 2'h0;
        retire(4'h0);
        // Falling edge on ext0 after a long high
        trig = 2'h1;
        en = '0;
        pin0 = 1'b0;
        tick(12);
        chk(rq0 === 1'b1, "edge flag set");
        en = '1;
        take(0, 0, 12);
        tick(2);
        chk(rq0 === 1'b0, "edge flag cleared");
        retire(4'h0);
        none(20);
        pin0 = 1'b1;
        // Held low level on ext1 requests again after return
        pin1 = 1'b0;
        take(2, 0, 12);
        tick(16);
        chk(rq1 === 1'b1, "level flag follows pin");
        rti();
        take(2, 0, 24);
        pin1 = 1'b1;
        retire(4'h0);
        close_out();
    end
endmodule : testbench
